// ---- common/sbnv_pkg.sv ----
/*
  package of the byte-wide nonvolatile memory port host: pin bundle, request and
  answer structs, and the cycle counts of the strobe sequence.
  assumes a 200 MHz core_clk; all times are rounded to whole cycles.
*/
// Behaviour
// - hold strobes low for access time
// - select high for minimum precharge after access
// - select never low beyond its maximum time
// - each access gets its own select fall
// - select held high during power transitions
// - write strobe high through power transitions
package sbnv_pkg;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CLK_PERIOD_NS = 5;
  // device figures, in ns
  localparam int unsigned ACCESS_TIME_NS = 70;
  localparam int unsigned PRECHARGE_TIME_MIN_NS = 60;
  localparam int unsigned SETUP_TIME_NS = 5;
  localparam int unsigned CE_LOW_MAX_NS = 10000;
  localparam int unsigned ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRECHARGE_CYC =
    (PRECHARGE_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CE_LOW_MAX_CYC = CE_LOW_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  // three extra cycles: two for the input synchroniser, one so that the
  // sampled byte is never taken at the very edge where it turns valid
  localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC + 3);
  localparam logic [CNT_W-1:0] PRECHARGE_CNT = CNT_W'(PRECHARGE_CYC);
  localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYC);
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] address_lines;
    logic [DATA_W-1:0] data_out;
    logic data_oe_n;
    logic chip_sel_n;
    logic write_n;
    logic out_drive_n;
  } sbnv_pins_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sbnv_req_t;

  typedef struct packed {
    logic done;
    logic [DATA_W-1:0] rdata;
  } sbnv_rsp_t;
endpackage

// ---- design/sbnv_sync.sv ----
/*
  two-flop synchroniser for the data lines read back from the memory.
  assumes the data lines are asynchronous to core_clk.
*/
module sbnv_sync #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sbnv_sync_st_t;

  sbnv_sync_st_t st_r;
  sbnv_sync_st_t st_nxt;

  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.sync;
endmodule

// ---- design/sbnv_host.sv ----
/*
  host controller for a byte-wide nonvolatile memory with strobed chip select.
  each request runs: setup, select fall, access, select rise, precharge.
  assumes the user holds a request stable while req.valid and not busy,
  and that the board turns the enables into real pin drive.
*/
module sbnv_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // user request and answer
  input wire sbnv_pkg::sbnv_req_t req,
  output logic busy,
  output sbnv_pkg::sbnv_rsp_t rsp,
  // memory pins
  input wire logic [sbnv_pkg::DATA_W-1:0] data_in,
  output sbnv_pkg::sbnv_pins_t pins
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS,
    ST_PRECHARGE
  } sbnv_state_t;

  typedef struct packed {
    sbnv_state_t state;
    logic [sbnv_pkg::CNT_W-1:0] cnt;
    logic is_write;
    logic busy;
    sbnv_pkg::sbnv_rsp_t rsp;
    sbnv_pkg::sbnv_pins_t pins;
  } sbnv_host_st_t;

  sbnv_host_st_t st_r;
  sbnv_host_st_t st_nxt;
  logic [sbnv_pkg::DATA_W-1:0] data_sync;

  // ===========================================================
  // read data synchroniser
  sbnv_sync #(
    .W(sbnv_pkg::DATA_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(data_in),
    .sync_out(data_sync)
  );

  // ===========================================================
  // strobe sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.done = 1'b0;
    unique case (st_r.state)
      ST_IDLE: begin
        // select parked high between accesses and from reset
        st_nxt.pins.chip_sel_n = 1'b1;
        st_nxt.pins.write_n = 1'b1;
        st_nxt.pins.out_drive_n = 1'b1;
        st_nxt.pins.data_oe_n = 1'b1;
        if (req.valid) begin
          st_nxt.state = ST_SETUP;
          st_nxt.busy = 1'b1;
          st_nxt.is_write = req.write;
          st_nxt.pins.address_lines = req.addr;
          st_nxt.pins.data_out = req.wdata;
          // write strobe low before select: select-controlled write
          st_nxt.pins.write_n = !req.write;
          st_nxt.pins.data_oe_n = !req.write;
          st_nxt.cnt = sbnv_pkg::SETUP_CNT;
        end
      end
      ST_SETUP: begin
        if (st_r.cnt <= 8'h01) begin
          // fresh select fall for every access latches the address
          st_nxt.pins.chip_sel_n = 1'b0;
          st_nxt.pins.out_drive_n = st_r.is_write;
          st_nxt.state = ST_ACCESS;
          st_nxt.cnt = sbnv_pkg::ACCESS_CNT;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      ST_ACCESS: begin
        // strobes held for the full access time, bounded well under max low
        if (st_r.cnt <= 8'h01) begin
          // write ends as select and strobe rise together
          st_nxt.pins.chip_sel_n = 1'b1;
          st_nxt.pins.write_n = 1'b1;
          st_nxt.pins.out_drive_n = 1'b1;
          st_nxt.state = ST_PRECHARGE;
          st_nxt.cnt = sbnv_pkg::PRECHARGE_CNT;
          if (!st_r.is_write) begin
            st_nxt.rsp.rdata = data_sync;
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      ST_PRECHARGE: begin
        // data released after the write strobe rises
        st_nxt.pins.data_oe_n = 1'b1;
        if (st_r.cnt <= 8'h01) begin
          // next access allowed straight away, no polling
          st_nxt.state = ST_IDLE;
          st_nxt.busy = 1'b0;
          // no done for the precharge wait that follows reset
          st_nxt.rsp.done = st_r.busy;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // a reset may cut an access: select then stays high a full precharge
      st_r.state <= ST_PRECHARGE;
      st_r.cnt <= sbnv_pkg::PRECHARGE_CNT;
      st_r.is_write <= 1'b0;
      st_r.busy <= 1'b0;
      st_r.rsp.done <= 1'b0;
      st_r.rsp.rdata <= sbnv_pkg::DATA_RST;
      st_r.pins.address_lines <= sbnv_pkg::ADDR_RST;
      st_r.pins.data_out <= sbnv_pkg::DATA_RST;
      st_r.pins.data_oe_n <= 1'b1;
      st_r.pins.chip_sel_n <= 1'b1;
      st_r.pins.write_n <= 1'b1;
      st_r.pins.out_drive_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
  assign rsp = st_r.rsp;
  assign pins = st_r.pins;
endmodule

// ---- bench/sbnv_host_asserts.sv ----
/*
  pin checks of sbnv_host.
  assumes the bind below.
*/
// ====
// checks
module sbnv_host_asserts (
  // clock, reset
  input wire logic core_clk,
  input wire logic rst_n,
  // watched
  input wire sbnv_pkg::sbnv_rsp_t rsp,
  input wire sbnv_pkg::sbnv_pins_t pins
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire sel_n = pins.chip_sel_n;
  property p_hold; $fell(sel_n) |-> (!sel_n) [*8] ##1 (!sel_n) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("low short");
  property p_pre; $rose(sel_n) |-> sel_n [*8] ##1 sel_n [*4]; endproperty
  a_pre: assert property (p_pre) else $error("high short");
  property p_low; $fell(sel_n) |-> ##[1:20] sel_n; endproperty
  a_low: assert property (p_low) else $error("low long");
  property p_one; $rose(sel_n) |-> ##12 rsp.done; endproperty
  a_one: assert property (p_one) else $error("no done");
  property p_rst_pre; $rose(rst_n) |-> sel_n [*8] ##1 sel_n [*4]; endproperty
  a_rst_pre: assert property (p_rst_pre) else $error("reset precharge short");
  property p_pwr; $rose(rst_n) |-> sel_n && pins.write_n; endproperty
  a_pwr: assert property (p_pwr) else $error("strobe low");
  property p_wr; !pins.write_n |-> ##[0:1] !sel_n; endproperty
  a_wr: assert property (p_wr) else $error("lone write");
endmodule
bind sbnv_host sbnv_host_asserts u_sbnv_host_asserts (
  .core_clk(core_clk), .rst_n(rst_n), .rsp(rsp), .pins(pins));

// ---- bench/sbnv_mem_model.sv ----
/*
  memory behind the host pins.
  assumes pins change after clock edges.
*/
// ====
// model
module sbnv_mem_model #(parameter int ACC_NS = 70) (
  // host pins
  input wire sbnv_pkg::sbnv_pins_t pins,
  // data drive
  output logic [7:0] mem_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [32768];
  int wear [4096];
  logic [14:0] lat_a;
  logic wr = 0;
  logic rdy = 0;
  wire oe = !pins.chip_sel_n && !pins.out_drive_n && !wr && rdy;
  initial mem_q = 8'h5a;
  always @(negedge pins.chip_sel_n) begin
    lat_a = pins.address_lines;
    wr = !pins.write_n;
    wear[lat_a[14:3]]++;
    rdy = 0;
    #(ACC_NS) rdy = 1;
  end
  always @(negedge pins.write_n)
    wr |= !pins.chip_sel_n;
  always @(posedge pins.write_n or posedge pins.chip_sel_n)
    if (wr) begin
      mem[lat_a] = pins.data_out;
      wr = 0;
    end
  // released lines show the inverse
  always @(oe)
    mem_q = (oe === 1'b1) ? mem[lat_a] : ~mem_q;
endmodule

// ---- bench/sbnv_host_tb.sv ----
/*
  bench of sbnv_host with the memory model.
  assumes the bound checker.
*/
// ====
// bench
module sbnv_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0;
  logic rst_n = 0;
  logic [7:0] mem_q, q;
  logic busy;
  sbnv_pkg::sbnv_req_t req = '0;
  sbnv_pkg::sbnv_rsp_t rsp;
  sbnv_pkg::sbnv_pins_t pins;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  wire [7:0] data_in = pins.data_oe_n ? mem_q : pins.data_out;
  always #2.5 core_clk = ~core_clk;
  sbnv_host u_sbnv_host (.core_clk(core_clk), .rst_n(rst_n), .req(req), .busy(busy),
    .rsp(rsp), .data_in(data_in), .pins(pins));
  sbnv_mem_model u_sbnv_mem_model (.pins(pins), .mem_q(mem_q));
  task automatic chk(logic [15:0] e, logic [15:0] g, string n);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xfer(logic w, logic [14:0] a, logic [7:0] d);
    int n = 0;
    int lat = sbnv_pkg::SETUP_CNT + sbnv_pkg::ACCESS_CNT + sbnv_pkg::PRECHARGE_CNT;
    req = '{1'b1, w, a, d};
    @(negedge core_clk);
    while (busy !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(16'h1, 16'(busy), "busy");
    req.valid = 0;
    n = 0;
    while (rsp.done !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    q = rsp.rdata;
    chk(16'(lat), 16'(n), "latency");
    chk(16'h0, 16'(busy), "idle");
  endtask
  task automatic t_rw;
    logic [14:0] a [4] = '{15'h0000, 15'h0007, 15'h0008, 15'h7fff};
    foreach (a[i])
      xfer(1'b1, a[i], 8'ha5 ^ 8'(i));
    for (int i = 3; i >= 0; i--) begin
      xfer(1'b0, a[i], 8'h00);
      chk(16'(8'ha5 ^ 8'(i)), 16'(q), "read");
    end
  endtask
  task automatic t_abort;
    req = '{1'b1, 1'b1, 15'h0100, 8'h11};
    repeat (10) @(negedge core_clk);
    rst_n = 0;
    req.valid = 0;
    repeat (3) @(negedge core_clk);
    chk(16'h3, 16'({pins.chip_sel_n, pins.write_n}), "rst pins");
    rst_n = 1;
    xfer(1'b0, 15'h0000, 8'h00);
    chk(16'ha5, 16'(q), "reread");
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1;
    t_rw();
    t_abort();
    give_verdict();
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
endmodule
